// File: hdl/srw_pkg.sv
// package of constants, register map and types for the reset and watchdog controller
package srw_pkg;
  // ***********************************
  // register map (word byte addresses)
  // ***********************************
  localparam logic [3:0] ADDR_CAUSE = 4'h0;
  localparam logic [3:0] ADDR_WDCTL = 4'h4;
  localparam logic [3:0] ADDR_UNLOCK = 4'h8;
  localparam logic [3:0] ADDR_MISC = 4'hc;
  localparam logic [7:0] UNLOCK_SIG = 8'hd8;
  // cause flag positions
  localparam int F_POWER = 0;
  localparam int F_PIN = 1;
  localparam int F_UNDERV = 2;
  localparam int F_WDOG = 3;
  // watchdog control and misc register positions
  localparam int W_IFLAG = 7;
  localparam int W_IEN = 6;
  localparam int W_P3 = 5;
  localparam int W_REN = 3;
  localparam int MISC_CMPBG = 0;
  localparam int MISC_CONV = 1;
  localparam int MISC_SLEEP = 2;
  localparam int MISC_REFON = 3;
  localparam logic [3:0] PERIOD_MAX = 4'h9;
  localparam int PERIOD_BASE_LOG2 = 9;
  localparam int UNLOCK_WINDOW = 4;
  localparam int SAMPLE_DIV = 32;
  // clock figures
  localparam int CLK_HZ = 50_000_000;
  localparam int LP_OSC_HZ = 32_768;
  localparam int LP_DIV = CLK_HZ / LP_OSC_HZ;
  localparam int WD_PULSE = 4;
  typedef enum logic [1:0] {
    UV_RSVD = 2'b00,
    UV_SAMPLED = 2'b01,
    UV_CONT = 2'b10,
    UV_OFF = 2'b11
  } srw_uvmode_t;
  typedef enum logic [1:0] {
    ST_HOLD = 2'b00,
    ST_COUNT = 2'b01,
    ST_RUN = 2'b11
  } srw_state_t;
  typedef struct packed {
    logic [3:0] period;
    logic resetEn;
    logic irqEn;
  } srw_wdcfg_t;
endpackage

// File: hdl/srw_reset_ctrl.sv
// reset sequencer, undervoltage mode logic and watchdog with wishbone registers
`timescale 1ns/10ps
// Function
// - hold every peripheral in reset while internal reset asserted; fetch resumes afterwards
// - port reset is registered and asserts on the next clock edge after any source goes active
// - after all sources release, run delay counter before releasing internal reset
// - four sources: power-on, enabled pin, enabled watchdog, enabled undervoltage
// - power-on starts delay; its return asserts reset on the next clock edge
// - low enabled pin resets on the next clock edge; delay runs after it rises
// - pin ignored during power-on count; extend only if still low at end
// - watchdog expiry gives short pulse; delay starts on its falling edge
// - undervoltage resets after persisting detect time, or at once on a sampled detection; held until cleared
// - sampled mode samples on 1kHz falling edge; detector off between samples
// - sampled detection switches to continuous until reset releases and fuses load
// - active fuse picks mode: 00 reserved, 01 sampled, 10 continuous, 11 off
// - sleep fuse picks mode in deep sleep with same encoding
// - reference enable is undervoltage on, comparator select, or converter on
// - watchdog counts low power clock; cleared by restart, disable, reset
// - ten periods; expiry without restart resets the device
// - lock fuse: level 1 off, timed disable; level 2 always on, timed period
// - protected changes need unlock signature then write within four cycles
// - period 512 to 256K cycles as powers of two; reserved codes clamp
// - with both actions, timeout interrupts and clears irq enable
// - sticky cause flags; power-on clears others; software writes zero to clear
module srw_reset_ctrl #(
  parameter int STRETCH_CYCLES = 64,
  parameter int DETECT_CYCLES = 8,
  parameter int LP_DIV_P = srw_pkg::LP_DIV
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic powerOnDetect,
  input wire logic extResetPinN,
  input wire logic extPinEnable,
  input wire logic undervoltageIndication,
  input wire logic [1:0] undervoltageActiveModeFuse,
  input wire logic [1:0] undervoltageSleepModeFuse,
  input wire logic watchdogLockFuse,
  input wire logic deepSleep,
  input wire logic watchdogRestart,
  input wire logic converterEnable,
  input wire logic [3:0] wbAdr,
  input wire logic [31:0] wbDatI,
  input wire logic [3:0] wbSel,
  input wire logic wbWe,
  input wire logic wbCyc,
  input wire logic wbStb,
  output logic [31:0] wbDatO,
  output logic wbAck,
  output logic portResetAsync,
  output logic internalReset,
  output logic watchdogIrq,
  output logic undervoltageDetectorOn,
  output logic referenceEnable
);
  // ***********************************
  // asynchronous source combine
  // ***********************************
  logic pinLow;
  logic srcAsync;
  logic wdPulse_reg;
  srw_pkg::srw_state_t state_reg;
  logic uvReset_reg;
  logic powerCount_reg;
  assign pinLow = extPinEnable & ~extResetPinN & ~powerCount_reg;
  // analog combine, no clock involved
  assign srcAsync = powerOnDetect | pinLow | uvReset_reg;
  always_ff @(posedge clk) begin
    portResetAsync <= srcAsync | wdPulse_reg | reset;
  end
  // ***********************************
  // release synchronizers
  // ***********************************
  logic [1:0] porSync_reg;
  logic [1:0] pinSync_reg;
  logic [1:0] uvSync_reg;
  always_ff @(posedge clk) begin
    porSync_reg <= {porSync_reg[0], powerOnDetect};
    pinSync_reg <= {pinSync_reg[0], extPinEnable & ~extResetPinN};
    uvSync_reg <= {uvSync_reg[0], undervoltageIndication};
  end
  logic porS;
  logic pinS;
  logic uvS;
  assign porS = porSync_reg[1];
  assign pinS = pinSync_reg[1];
  assign uvS = uvSync_reg[1];
  // ***********************************
  // stretch sequencer
  // ***********************************
  logic [$clog2(STRETCH_CYCLES+1)-1:0] stretch_reg;
  logic holdSrc;
  logic wdExpire;
  assign holdSrc = porS | uvReset_reg | wdPulse_reg | (pinS & ~powerCount_reg);
  always_ff @(posedge clk) begin
    if (reset || porS) begin
      state_reg <= srw_pkg::ST_HOLD;
      stretch_reg <= '0;
      powerCount_reg <= 1'b1;
    end else begin
      case (state_reg)
        srw_pkg::ST_HOLD: begin
          stretch_reg <= '0;
          if (!holdSrc) begin
            state_reg <= srw_pkg::ST_COUNT;
          end
        end
        srw_pkg::ST_COUNT: begin
          if (holdSrc) begin
            state_reg <= srw_pkg::ST_HOLD;
          end else if (stretch_reg == ($bits(stretch_reg))'(STRETCH_CYCLES - 1)) begin
            if (powerCount_reg && pinS) begin
              state_reg <= srw_pkg::ST_HOLD;
            end else begin
              state_reg <= srw_pkg::ST_RUN;
            end
            powerCount_reg <= 1'b0;
          end else begin
            stretch_reg <= stretch_reg + 1'b1;
          end
        end
        srw_pkg::ST_RUN: begin
          if (pinS || uvReset_reg || wdExpire) begin
            state_reg <= srw_pkg::ST_HOLD;
          end
        end
        default: state_reg <= srw_pkg::ST_HOLD;
      endcase
    end
  end
  logic chipReset;
  assign chipReset = reset | (state_reg != srw_pkg::ST_RUN);
  always_ff @(posedge clk) begin
    internalReset <= reset | (state_reg != srw_pkg::ST_RUN) | srcAsync;
  end
  // ***********************************
  // low power clock enables
  // ***********************************
  logic [15:0] lpDiv_reg;
  logic lpTick;
  logic [4:0] sampDiv_reg;
  logic sampleTick;
  assign lpTick = lpDiv_reg == 16'(LP_DIV_P - 1);
  // falling edge of the 1kHz clock = wrap of the 32 divider
  assign sampleTick = lpTick & (sampDiv_reg == 5'(srw_pkg::SAMPLE_DIV - 1));
  always_ff @(posedge clk) begin
    // divider never reset by the chip reset it stretches
    if (reset) begin
      lpDiv_reg <= '0;
      sampDiv_reg <= '0;
    end else begin
      lpDiv_reg <= lpTick ? 16'h0000 : lpDiv_reg + 16'h0001;
      if (lpTick) begin
        sampDiv_reg <= sampDiv_reg + 5'h01;
      end
    end
  end
  // ***********************************
  // undervoltage detector mode
  // ***********************************
  srw_pkg::srw_uvmode_t uvMode;
  logic forceCont_reg;
  logic uvEnabled;
  logic [$clog2(DETECT_CYCLES+1)-1:0] detect_reg;
  assign uvMode = srw_pkg::srw_uvmode_t'(deepSleep ? undervoltageSleepModeFuse
                                                   : undervoltageActiveModeFuse);
  // reserved code treated as continuous, the safe choice
  assign uvEnabled = forceCont_reg | (uvMode != srw_pkg::UV_OFF);
  always_ff @(posedge clk) begin
    if (reset) begin
      forceCont_reg <= 1'b0;
      uvReset_reg <= 1'b0;
      detect_reg <= '0;
      undervoltageDetectorOn <= 1'b0;
    end else begin
      undervoltageDetectorOn <= forceCont_reg | (uvMode == srw_pkg::UV_CONT)
          | (uvMode == srw_pkg::UV_RSVD) | ((uvMode == srw_pkg::UV_SAMPLED) & sampleTick);
      if (!uvEnabled || !uvS) begin
        detect_reg <= '0;
        uvReset_reg <= 1'b0;
      end else if (!forceCont_reg && uvMode == srw_pkg::UV_SAMPLED) begin
        if (sampleTick) begin
          forceCont_reg <= 1'b1;
          uvReset_reg <= 1'b1;
        end
      end else if (detect_reg == ($bits(detect_reg))'(DETECT_CYCLES - 1)) begin
        uvReset_reg <= 1'b1;
      end else begin
        detect_reg <= detect_reg + 1'b1;
      end
      if (forceCont_reg && !uvReset_reg && !chipReset) begin
        forceCont_reg <= 1'b0;
      end
    end
  end
  // ***********************************
  // watchdog registers
  // ***********************************
  srw_pkg::srw_wdcfg_t wdCfg_reg;
  logic wdIrqFlag_reg;
  logic [3:0] cause_reg;
  logic cmpBandgap_reg;
  logic [2:0] unlockCnt_reg;
  logic unlocked;
  logic wbReq;
  logic wbWrite;
  logic running;
  logic [3:0] effPeriod;
  logic wdTimeout;
  assign wbReq = wbCyc & wbStb & ~wbAck;
  assign wbWrite = wbCyc & wbStb & wbAck & wbWe & wbSel[0]; // lands at the ack edge
  assign unlocked = unlockCnt_reg != 3'h0;
  assign running = wdCfg_reg.resetEn | wdCfg_reg.irqEn | watchdogLockFuse;
  assign effPeriod = (wdCfg_reg.period > srw_pkg::PERIOD_MAX) ? srw_pkg::PERIOD_MAX
                                                              : wdCfg_reg.period;
  always_ff @(posedge clk) begin
    if (chipReset) begin
      unlockCnt_reg <= '0;
    end else if (wbWrite && wbAdr == srw_pkg::ADDR_UNLOCK && wbDatI[7:0] == srw_pkg::UNLOCK_SIG) begin
      unlockCnt_reg <= 3'(srw_pkg::UNLOCK_WINDOW);
    end else if (unlocked) begin
      unlockCnt_reg <= unlockCnt_reg - 3'h1;
    end
  end
  logic [7:0] wdWr;
  logic newRen;
  assign wdWr = wbDatI[7:0];
  always_comb begin
    newRen = wdCfg_reg.resetEn;
    if (wdWr[srw_pkg::W_REN] || unlocked) begin
      newRen = wdWr[srw_pkg::W_REN];
    end
  end
  always_ff @(posedge clk) begin
    if (chipReset) begin
      wdCfg_reg <= '0;
      wdIrqFlag_reg <= 1'b0;
      cmpBandgap_reg <= 1'b0;
    end else begin
      if (wbWrite && wbAdr == srw_pkg::ADDR_WDCTL) begin
        wdCfg_reg.irqEn <= wdWr[srw_pkg::W_IEN];
        if (!watchdogLockFuse || unlocked) begin
          wdCfg_reg.period <= {wdWr[srw_pkg::W_P3], wdWr[2:0]};
        end
        if (!watchdogLockFuse) begin
          wdCfg_reg.resetEn <= newRen;
        end
      end
      if (wbWrite && wbAdr == srw_pkg::ADDR_MISC) begin
        cmpBandgap_reg <= wbDatI[srw_pkg::MISC_CMPBG];
      end
      if (wdTimeout && wdCfg_reg.irqEn) begin
        wdIrqFlag_reg <= 1'b1;
        if (wdCfg_reg.resetEn || watchdogLockFuse) begin
          wdCfg_reg.irqEn <= 1'b0;
        end
      end else if (wbWrite && wbAdr == srw_pkg::ADDR_WDCTL && wdWr[srw_pkg::W_IFLAG]) begin
        wdIrqFlag_reg <= 1'b0;
      end
    end
  end
  // ***********************************
  // watchdog counter
  // ***********************************
  logic [17:0] wdCnt_reg;
  logic [17:0] wdLimit;
  logic [2:0] pulseCnt_reg;
  assign wdLimit = 18'((32'h1 << (srw_pkg::PERIOD_BASE_LOG2 + 32'(effPeriod))) - 32'h1);
  assign wdTimeout = running & lpTick & (wdCnt_reg == wdLimit);
  assign wdExpire = wdTimeout & ~wdCfg_reg.irqEn &
                    (wdCfg_reg.resetEn | watchdogLockFuse);
  always_ff @(posedge clk) begin
    if (chipReset || watchdogRestart || !running) begin
      wdCnt_reg <= '0;
    end else if (lpTick) begin
      wdCnt_reg <= wdTimeout ? 18'h00000 : wdCnt_reg + 18'h00001;
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      wdPulse_reg <= 1'b0;
      pulseCnt_reg <= '0;
    end else if (wdExpire) begin
      wdPulse_reg <= 1'b1;
      pulseCnt_reg <= 3'(srw_pkg::WD_PULSE - 1);
    end else if (pulseCnt_reg != 3'h0) begin
      pulseCnt_reg <= pulseCnt_reg - 3'h1;
    end else begin
      wdPulse_reg <= 1'b0;
    end
  end
  // ***********************************
  // cause flags
  // ***********************************
  always_ff @(posedge clk) begin
    if (reset || porS) begin
      cause_reg <= 4'h1;
    end else begin
      if (wbWrite && wbAdr == srw_pkg::ADDR_CAUSE) begin
        cause_reg <= cause_reg & wbDatI[3:0];
      end
      // set after clear so a concurrent event wins
      if (pinS && !powerCount_reg) begin
        cause_reg[srw_pkg::F_PIN] <= 1'b1;
      end
      if (uvReset_reg) begin
        cause_reg[srw_pkg::F_UNDERV] <= 1'b1;
      end
      if (wdExpire) begin
        cause_reg[srw_pkg::F_WDOG] <= 1'b1;
      end
    end
  end
  // ***********************************
  // reference, irq and bus answer
  // ***********************************
  always_ff @(posedge clk) begin
    // software owns start-up wait of the reference
    referenceEnable <= uvEnabled | cmpBandgap_reg | converterEnable;
    watchdogIrq <= wdIrqFlag_reg & ~chipReset;
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      wbAck <= 1'b0;
      wbDatO <= '0;
    end else begin
      wbAck <= wbReq;
      wbDatO <= '0;
      if (wbReq && !wbWe) begin
        case (wbAdr)
          srw_pkg::ADDR_CAUSE: wbDatO <= {28'h0, cause_reg};
          srw_pkg::ADDR_WDCTL: wbDatO <= {24'h0, wdIrqFlag_reg, wdCfg_reg.irqEn,
              wdCfg_reg.period[3], 1'b0, wdCfg_reg.resetEn | watchdogLockFuse,
              wdCfg_reg.period[2:0]};
          srw_pkg::ADDR_MISC: wbDatO <= {28'h0, uvEnabled, deepSleep, converterEnable,
              cmpBandgap_reg};
          default: wbDatO <= '0;
        endcase
      end
    end
  end
  // ***********************************
  // checks
  // ***********************************
  a_power_hold: assert property (@(posedge clk) disable iff (reset)
    porS |=> internalReset) else $error("power-on did not hold reset");
  a_port_async: assert property (@(posedge clk) disable iff (reset)
    srcAsync |=> portResetAsync) else $error("port reset missing");
  a_stretch_len: assert property (@(posedge clk) disable iff (reset)
    (state_reg == srw_pkg::ST_HOLD && !holdSrc && !porS) |=> internalReset [*2])
    else $error("stretch too short");
  a_pulse_short: assert property (@(posedge clk) disable iff (reset)
    $rose(wdPulse_reg) |-> ##[1:8] !wdPulse_reg) else $error("watchdog pulse too long");
  a_irq_clears: assert property (@(posedge clk) disable iff (reset)
    (wdTimeout && wdCfg_reg.irqEn && wdCfg_reg.resetEn && !chipReset) |=> !wdCfg_reg.irqEn)
    else $error("irq enable not cleared");
  a_ref_or: assert property (@(posedge clk) disable iff (reset)
    cmpBandgap_reg |=> referenceEnable) else $error("reference off");
  a_uv_cont: assert property (@(posedge clk) disable iff (reset)
    (sampleTick && uvS && uvMode == srw_pkg::UV_SAMPLED && !forceCont_reg) |=> forceCont_reg)
    else $error("no switch to continuous");
  a_wd_clear: assert property (@(posedge clk) disable iff (reset)
    watchdogRestart |=> wdCnt_reg == 18'h00000) else $error("watchdog not cleared");
  a_period_clamp: assert property (@(posedge clk) disable iff (reset)
    effPeriod <= srw_pkg::PERIOD_MAX) else $error("period out of range");
  c_wd_reset: cover property (@(posedge clk) wdExpire);
  c_uv_reset: cover property (@(posedge clk) $rose(uvReset_reg));
  c_wd_irq: cover property (@(posedge clk) $rose(wdIrqFlag_reg));
endmodule // srw_reset_ctrl

// File: verif/srw_reset_ctrl_tb.sv
// self-checking bench for the reset sequencer and watchdog
`timescale 1ns/10ps
module srw_reset_ctrl_tb;
  localparam int ST = 8;
  localparam int WDT0 = 512 * 4;
  logic clk, reset, dipReq, lowReq, extResetPinN, extPinEnable, watchdogLockFuse, deepSleep;
  logic watchdogRestart, converterEnable, wbWe, wbCyc, wbStb, wbAck, portResetAsync;
  logic internalReset, watchdogIrq, undervoltageDetectorOn, referenceEnable;
  logic powerOnDetect, undervoltageIndication, refReady;
  logic [1:0] actFuse, slpFuse;
  logic [3:0] wbAdr, wbSel;
  logic [31:0] wbDatI, wbDatO, rd;
  int n_fail = 0;
  int num_checks = 0;
  int cyc = 0;
  int n, k, m, bad;
  srw_reset_ctrl #(.STRETCH_CYCLES(ST), .DETECT_CYCLES(2), .LP_DIV_P(4)) u_dut (
    .clk(clk), .reset(reset), .powerOnDetect(powerOnDetect), .extResetPinN(extResetPinN),
    .extPinEnable(extPinEnable), .undervoltageIndication(undervoltageIndication),
    .undervoltageActiveModeFuse(actFuse), .undervoltageSleepModeFuse(slpFuse),
    .watchdogLockFuse(watchdogLockFuse), .deepSleep(deepSleep), .watchdogRestart(watchdogRestart),
    .converterEnable(converterEnable), .wbAdr(wbAdr), .wbDatI(wbDatI), .wbSel(wbSel), .wbWe(wbWe),
    .wbCyc(wbCyc), .wbStb(wbStb), .wbDatO(wbDatO), .wbAck(wbAck), .portResetAsync(portResetAsync),
    .internalReset(internalReset), .watchdogIrq(watchdogIrq),
    .undervoltageDetectorOn(undervoltageDetectorOn), .referenceEnable(referenceEnable));
  srw_supply_model u_sup (.clk(clk), .dipReq(dipReq), .lowReq(lowReq),
    .referenceEnable(referenceEnable), .powerOnDetect(powerOnDetect),
    .undervoltageIndication(undervoltageIndication), .refReady(refReady));
  // ***********************************
  // bench tasks
  // ***********************************
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_fail++;
      complete_run;
    end
  end
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // classic single cycle; never assumes the answer time
  task automatic wb(input logic [3:0] a, input logic w, input logic [7:0] d);
    int t;
    t = 0;
    @(posedge clk);
    {wbCyc, wbStb, wbWe} <= {2'b11, w};
    wbAdr <= a;
    wbSel <= 4'hf;
    wbDatI <= {24'h0, d};
    do begin
      @(posedge clk);
      t++;
    end while (wbAck !== 1'b1 && t < 20);
    rd = wbDatO;
    {wbCyc, wbStb, wbWe} <= 3'b000;
    chk("wbAck", 1, t < 20);
  endtask
  task automatic rdc(input string nm, input logic [3:0] a, input logic [31:0] e);
    wb(a, 1'b0, 8'h00);
    chk(nm, e, rd);
  endtask
  task automatic waitRel;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (internalReset !== 1'b0 && n < 5000);
    chk("release", 1, n < 5000);
  endtask
  task automatic waitSig(input int w, input int lim);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while ((w ? watchdogIrq : internalReset) !== 1'b1 && n < lim);
  endtask
  task automatic doReset;
    reset <= 1'b1;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    waitRel;
  endtask
  // ***********************************
  // main sequence
  // ***********************************
  initial begin
    {reset, dipReq, lowReq, extPinEnable, watchdogLockFuse, deepSleep} = 6'h21;
    {watchdogRestart, converterEnable, wbWe, wbCyc, wbStb, extResetPinN} = 6'h01;
    {actFuse, slpFuse, wbAdr, wbSel, wbDatI} = {4'hf, 4'h0, 4'hf, 32'h0};
    k = $urandom(88082);
    doReset;
    chk("stretch", 1, n > ST);
    rdc("wdAfterReset", srw_pkg::ADDR_WDCTL, 32'h0);
    wb(srw_pkg::ADDR_CAUSE, 1'b1, 8'h00);
    for (m = 1; m < 4; m++) begin
      wb(4'(m * 4 + 2), 1'b1, 8'($urandom));
      rdc("unmapped", 4'(m * 4 + 2), 32'h0);
    end
    extPinEnable <= 1'b1;
    extResetPinN <= 1'b0;
    repeat (3) @(posedge clk);
    chk("portReset", 1, portResetAsync);
    extResetPinN <= 1'b1;
    repeat (5) @(posedge clk);
    chk("portRelease", 0, portResetAsync);
    chk("stillHeld", 1, internalReset);
    waitRel;
    rdc("causePin", srw_pkg::ADDR_CAUSE, 32'h2);
    extPinEnable <= 1'b0;
    extResetPinN <= 1'b0;
    repeat (20) @(posedge clk);
    chk("pinDisabled", 0, internalReset);
    extResetPinN <= 1'b1;
    extPinEnable <= 1'b1;
    dipReq <= 1'b1;
    repeat (3) @(posedge clk);
    chk("powerAssert", 1, internalReset);
    repeat (7) @(posedge clk);
    dipReq <= 1'b0;
    repeat (4) @(posedge clk);
    extResetPinN <= 1'b0;
    repeat (2) @(posedge clk);
    extResetPinN <= 1'b1;
    waitRel;
    rdc("causePower", srw_pkg::ADDR_CAUSE, 32'h1);
    wb(srw_pkg::ADDR_CAUSE, 1'b1, 8'h00);
    rdc("causeClear", srw_pkg::ADDR_CAUSE, 32'h0);
    for (int s = 0; s < 8; s++) begin
      m = s % 4;
      deepSleep <= (s >= 4);
      actFuse <= (s >= 4) ? 2'(3 - m) : 2'(m);
      slpFuse <= (s >= 4) ? 2'(m) : 2'(3 - m);
      doReset;
      k = 0;
      repeat (256) begin
        @(posedge clk);
        k += int'(undervoltageDetectorOn === 1'b1);
      end
      chk("detOn", (m == 3) ? 0 : (m == 1) ? 1 : 256, (m == 1) ? (k > 0 && k < 256) : k);
      if (m != 1) chk("refEn", m != 3, referenceEnable);
    end
    {deepSleep, actFuse, slpFuse} <= 5'b00111;
    doReset;
    lowReq <= 1'b1;
    waitSig(0, 400);
    repeat (40) @(posedge clk);
    chk("sampledHold", 2'b11, {internalReset, undervoltageDetectorOn});
    lowReq <= 1'b0;
    waitRel;
    k = 0;
    repeat (256) begin
      @(posedge clk);
      k += int'(undervoltageDetectorOn === 1'b1);
    end
    chk("backToSampled", 1, k > 0 && k < 256);
    actFuse <= 2'b10;
    doReset;
    wb(srw_pkg::ADDR_CAUSE, 1'b1, 8'h00);
    lowReq <= 1'b1;
    repeat ($urandom_range(40, 20)) @(posedge clk);
    chk("uvHold", 1, internalReset);
    lowReq <= 1'b0;
    waitRel;
    chk("uvStretch", 1, n > ST);
    rdc("causeUv", srw_pkg::ADDR_CAUSE, 32'h4);
    actFuse <= 2'b11;
    doReset;
    wb(srw_pkg::ADDR_MISC, 1'b1, 8'h01);
    chk("cmpNoReset", 0, internalReset);
    for (n = 0; n < 20 && refReady !== 1'b1; n++) @(posedge clk);
    chk("refReady", 1, refReady);
    chk("refCmp", 1, referenceEnable);
    rdc("miscCmp", srw_pkg::ADDR_MISC, 32'h1);
    wb(srw_pkg::ADDR_MISC, 1'b1, 8'h00);
    converterEnable <= 1'b1;
    rdc("miscConv", srw_pkg::ADDR_MISC, 32'h2);
    chk("refConv", 1, referenceEnable);
    converterEnable <= 1'b0;
    repeat (3) @(posedge clk);
    chk("refOff", 0, referenceEnable);
    wb(srw_pkg::ADDR_WDCTL, 1'b1, 8'h08);
    wb(srw_pkg::ADDR_WDCTL, 1'b1, 8'h00);
    rdc("lockedOff", srw_pkg::ADDR_WDCTL, 32'h08);
    wb(srw_pkg::ADDR_UNLOCK, 1'b1, srw_pkg::UNLOCK_SIG);
    wb(srw_pkg::ADDR_WDCTL, 1'b1, 8'h00);
    rdc("unlockedOff", srw_pkg::ADDR_WDCTL, 32'h00);
    wb(srw_pkg::ADDR_CAUSE, 1'b1, 8'h00);
    wb(srw_pkg::ADDR_WDCTL, 1'b1, 8'h08);
    waitSig(0, 3000);
    chk("wdPeriod", 1, n >= WDT0 - 8 && n <= WDT0 + 24);
    waitRel;
    chk("wdStretch", 1, n > ST);
    rdc("causeWd", srw_pkg::ADDR_CAUSE, 32'h8);
    rdc("wdCleared", srw_pkg::ADDR_WDCTL, 32'h0);
    wb(srw_pkg::ADDR_WDCTL, 1'b1, 8'h40);
    waitSig(1, 3000);
    chk("irqNoReset", 2'b10, {watchdogIrq, internalReset});
    rdc("irqFlag", srw_pkg::ADDR_WDCTL, 32'hc0);
    wb(srw_pkg::ADDR_WDCTL, 1'b1, 8'h80);
    rdc("irqCleared", srw_pkg::ADDR_WDCTL, 32'h00);
    wb(srw_pkg::ADDR_WDCTL, 1'b1, 8'h48);
    waitSig(1, 3000);
    rdc("bothFirst", srw_pkg::ADDR_WDCTL, 32'h88);
    waitSig(0, 3000);
    chk("bothSecond", 1, internalReset);
    waitRel;
    wb(srw_pkg::ADDR_WDCTL, 1'b1, 8'h08);
    bad = 0;
    repeat (4) begin
      repeat ($urandom_range(1800, 1000)) begin
        @(posedge clk);
        bad += int'(internalReset !== 1'b0);
      end
      watchdogRestart <= 1'b1;
      @(posedge clk);
      watchdogRestart <= 1'b0;
    end
    chk("restartHolds", 0, bad);
    watchdogLockFuse <= 1'b1;
    doReset;
    rdc("level2On", srw_pkg::ADDR_WDCTL, 32'h08);
    wb(srw_pkg::ADDR_WDCTL, 1'b1, 8'h01);
    rdc("level2Locked", srw_pkg::ADDR_WDCTL, 32'h08);
    wb(srw_pkg::ADDR_UNLOCK, 1'b1, srw_pkg::UNLOCK_SIG);
    wb(srw_pkg::ADDR_WDCTL, 1'b1, 8'h01);
    rdc("level2Period", srw_pkg::ADDR_WDCTL, 32'h09);
    complete_run;
  end
endmodule // srw_reset_ctrl_tb

// File: verif/srw_supply_model.sv
// supply monitor and bandgap start-up model facing the reset controller
`timescale 1ns/10ps
module srw_supply_model #(
  parameter int REF_START = 5
) (
  input wire logic clk,
  input wire logic dipReq,
  input wire logic lowReq,
  input wire logic referenceEnable,
  output logic powerOnDetect,
  output logic undervoltageIndication,
  output logic refReady
);
  int refCnt;
  initial begin
    powerOnDetect = 1'b0;
    undervoltageIndication = 1'b0;
    refCnt = 0;
  end
  // detector levels follow the requested supply shape
  always @(posedge clk) begin
    powerOnDetect <= dipReq;
    undervoltageIndication <= lowReq;
  end
  // user side must not trust the reference before it has started up
  always @(posedge clk) begin
    if (referenceEnable !== 1'b1) refCnt <= 0;
    else if (refCnt < REF_START) refCnt <= refCnt + 1;
  end
  assign refReady = (referenceEnable === 1'b1) && (refCnt == REF_START);
endmodule // srw_supply_model
